// >>> rivm_pkg.sv
/*
  Package for the reset and interrupt vector map: table offsets, vector
  numbers, widths and state codes.
  Assumes word-addressed program memory and one core clock.
*/
package rivm_pkg;

  // ---------------------------------------------------------------
  // Address geometry
  // ---------------------------------------------------------------
  localparam int unsigned RIVM_AW       = 12;
  localparam int unsigned RIVM_NSRC     = 25;
  localparam int unsigned RIVM_IDW      = 5;

  localparam logic [11:0] RIVM_RESET_ADDR   = 12'h000;
  localparam logic [11:0] RIVM_TABLE_START  = 12'h001;
  localparam logic [11:0] RIVM_BOOT_DEFAULT = 12'hc00;

  // ---------------------------------------------------------------
  // Table offsets, one word each
  // ---------------------------------------------------------------
  localparam logic [11:0] RIVM_OFS_EXT_IRQ_ZERO    = 12'h001;
  localparam logic [11:0] RIVM_OFS_EXT_IRQ_ONE     = 12'h002;
  localparam logic [11:0] RIVM_OFS_PIN_CHG_ZERO    = 12'h003;
  localparam logic [11:0] RIVM_OFS_PIN_CHG_ONE     = 12'h004;
  localparam logic [11:0] RIVM_OFS_PIN_CHG_TWO     = 12'h005;
  localparam logic [11:0] RIVM_OFS_WATCHDOG        = 12'h006;
  localparam logic [11:0] RIVM_OFS_T2_MATCH_A      = 12'h007;
  localparam logic [11:0] RIVM_OFS_T2_MATCH_B      = 12'h008;
  localparam logic [11:0] RIVM_OFS_T2_OVERFLOW     = 12'h009;
  localparam logic [11:0] RIVM_OFS_T1_CAPTURE      = 12'h00a;
  localparam logic [11:0] RIVM_OFS_T1_MATCH_A      = 12'h00b;
  localparam logic [11:0] RIVM_OFS_T1_MATCH_B      = 12'h00c;
  localparam logic [11:0] RIVM_OFS_T1_OVERFLOW     = 12'h00d;
  localparam logic [11:0] RIVM_OFS_T0_MATCH_A      = 12'h00e;
  localparam logic [11:0] RIVM_OFS_T0_MATCH_B      = 12'h00f;
  localparam logic [11:0] RIVM_OFS_T0_OVERFLOW     = 12'h010;
  localparam logic [11:0] RIVM_OFS_SPI_DONE        = 12'h011;
  localparam logic [11:0] RIVM_OFS_SERIAL_RX_DONE  = 12'h012;
  localparam logic [11:0] RIVM_OFS_SERIAL_TX_EMPTY = 12'h013;
  localparam logic [11:0] RIVM_OFS_SERIAL_TX_DONE  = 12'h014;
  localparam logic [11:0] RIVM_OFS_CONV_DONE       = 12'h015;
  localparam logic [11:0] RIVM_OFS_NV_DATA_READY   = 12'h016;
  localparam logic [11:0] RIVM_OFS_ANALOG_CMP      = 12'h017;
  localparam logic [11:0] RIVM_OFS_TWO_WIRE        = 12'h018;
  localparam logic [11:0] RIVM_OFS_SELF_PROG_READY = 12'h019;

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RIVM_ST_RESET = 3'h1,
    RIVM_ST_RUN   = 3'h2,
    RIVM_ST_VEC   = 3'h4
  } rivm_state_t;

endpackage : rivm_pkg

// >>> rivm_vector_map.sv
/*
  Reset and interrupt vector address generator. Emits a one-cycle fetch
  redirect after reset and whenever the core accepts an interrupt whose
  source number is in the table (1..25), except on the first clock after reset.
  Assumes the core arbitrates priority and passes one accepted vector
  number with a strobe; fuse and select bit are static core-side levels.
*/
// Operation
// [RULE1] Fuse unprogrammed: every reset source starts fetch at word zero.
// [RULE2] External request zero and one vectors at offsets 0x001 and 0x002.
// [RULE3] Pin change groups at 0x003..0x005, watchdog time-out at 0x006.
// [RULE4] Timer two: match A 0x007, match B 0x008, overflow 0x009.
// [RULE5] Timer one: capture 0x00A, match A 0x00B, match B 0x00C, overflow 0x00D.
// [RULE6] Timer zero: match A 0x00E, match B 0x00F, overflow 0x010.
// [RULE7] Serial peripheral 0x011; serial port receive, empty, transmit 0x012..0x014.
// [RULE8] Converter, data memory, comparator, two-wire, store ready at 0x015..0x019.
// [RULE9] Fuse programmed: reset fetch starts at the boot reset address.
// [RULE10] Select bit set: vector address is boot start plus table offset.
// [RULE11] Reset target boot only for fuse 0; table start 0x001 or boot+0x001.
// [RULE12] Vector locations are fetched only when that interrupt is taken.
// [RULE13] One word per vector: address equals table base plus n.
`timescale 1ns/1ps

module rivm_vector_map
  import rivm_pkg::*;
#(
  parameter int unsigned          AW              = RIVM_AW,
  parameter logic [RIVM_AW-1:0]   BOOT_RESET_ADDR = RIVM_BOOT_DEFAULT
) (
  input  wire logic                 CLK,              // Core clock, 20 MHz
  input  wire logic                 RSTN,             // Async reset, active low
  input  wire logic                 BOOT_RESET_SELECT_FUSE, // 0 = programmed
  input  wire logic                 VECTOR_TABLE_SELECT_BIT, // 1 = table in boot
  input  wire logic                 IRQ_TAKEN,        // Core accepted a request
  input  wire logic [RIVM_IDW-1:0]  IRQ_SOURCE,       // Source 1..25, table order
  output logic                      FETCH_LOAD,       // Redirect fetch this cycle
  output logic [AW-1:0]             FETCH_ADDR,       // Word address to fetch
  output logic                      FETCH_IS_RESET,   // Redirect is the reset one
  output logic                      SOURCE_ERROR      // Bad source number seen
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (AW != RIVM_AW) begin : g_bad_aw
    $error("rivm_vector_map: address width must match the package");
  end

  if (int'(BOOT_RESET_ADDR) + int'(RIVM_OFS_SELF_PROG_READY) >= (1 << AW)) begin : g_bad_boot
    $error("rivm_vector_map: boot table would run past the end of program memory");
  end

  if (RIVM_NSRC >= (1 << RIVM_IDW)) begin : g_bad_nsrc
    $error("rivm_vector_map: source numbers do not fit the source port");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rivm_state_t        st;
    logic               load;
    logic               is_reset;
    logic               err;
    logic [AW-1:0]      addr;
  } rivm_regs_t;

  rivm_regs_t r_q;
  rivm_regs_t r_d;

  // ---------------------------------------------------------------
  // Source numbers, equal to the table offset of their vector
  // ---------------------------------------------------------------
  // External requests, pin change groups, watchdog
  localparam logic [RIVM_IDW-1:0] SRC_EXT_IRQ_ZERO    = 5'h01;
  localparam logic [RIVM_IDW-1:0] SRC_EXT_IRQ_ONE     = 5'h02;
  localparam logic [RIVM_IDW-1:0] SRC_PIN_CHG_ZERO    = 5'h03;
  localparam logic [RIVM_IDW-1:0] SRC_PIN_CHG_ONE     = 5'h04;
  localparam logic [RIVM_IDW-1:0] SRC_PIN_CHG_TWO     = 5'h05;
  localparam logic [RIVM_IDW-1:0] SRC_WATCHDOG        = 5'h06;

  // Timer two
  localparam logic [RIVM_IDW-1:0] SRC_T2_MATCH_A      = 5'h07;
  localparam logic [RIVM_IDW-1:0] SRC_T2_MATCH_B      = 5'h08;
  localparam logic [RIVM_IDW-1:0] SRC_T2_OVERFLOW     = 5'h09;

  // Timer one
  localparam logic [RIVM_IDW-1:0] SRC_T1_CAPTURE      = 5'h0a;
  localparam logic [RIVM_IDW-1:0] SRC_T1_MATCH_A      = 5'h0b;
  localparam logic [RIVM_IDW-1:0] SRC_T1_MATCH_B      = 5'h0c;
  localparam logic [RIVM_IDW-1:0] SRC_T1_OVERFLOW     = 5'h0d;

  // Timer zero
  localparam logic [RIVM_IDW-1:0] SRC_T0_MATCH_A      = 5'h0e;
  localparam logic [RIVM_IDW-1:0] SRC_T0_MATCH_B      = 5'h0f;
  localparam logic [RIVM_IDW-1:0] SRC_T0_OVERFLOW     = 5'h10;

  // Serial peripheral and serial port
  localparam logic [RIVM_IDW-1:0] SRC_SPI_DONE        = 5'h11;
  localparam logic [RIVM_IDW-1:0] SRC_SERIAL_RX_DONE  = 5'h12;
  localparam logic [RIVM_IDW-1:0] SRC_SERIAL_TX_EMPTY = 5'h13;
  localparam logic [RIVM_IDW-1:0] SRC_SERIAL_TX_DONE  = 5'h14;

  // Converter, data memory, comparator, two-wire, store
  localparam logic [RIVM_IDW-1:0] SRC_CONV_DONE       = 5'h15;
  localparam logic [RIVM_IDW-1:0] SRC_NV_DATA_READY   = 5'h16;
  localparam logic [RIVM_IDW-1:0] SRC_ANALOG_CMP      = 5'h17;
  localparam logic [RIVM_IDW-1:0] SRC_TWO_WIRE        = 5'h18;
  localparam logic [RIVM_IDW-1:0] SRC_SELF_PROG_READY = 5'h19;

  // ---------------------------------------------------------------
  // Vector table
  // ---------------------------------------------------------------
  // Offset and valid flag per source. Slot 0 is the reset word, so it
  // and anything past the last vector come back invalid
  function automatic logic [AW:0] rivm_entry(input logic [RIVM_IDW-1:0] n);
    logic          vld;
    logic [AW-1:0] ofs;
    vld = 1'b0;
    ofs = '0;
    case (n)
      SRC_EXT_IRQ_ZERO: begin
        vld = 1'b1;
        ofs = RIVM_OFS_EXT_IRQ_ZERO;  // RULE2
      end
      SRC_EXT_IRQ_ONE: begin
        vld = 1'b1;
        ofs = RIVM_OFS_EXT_IRQ_ONE;  // RULE2
      end
      SRC_PIN_CHG_ZERO: begin
        vld = 1'b1;
        ofs = RIVM_OFS_PIN_CHG_ZERO;  // RULE3
      end
      SRC_PIN_CHG_ONE: begin
        vld = 1'b1;
        ofs = RIVM_OFS_PIN_CHG_ONE;  // RULE3
      end
      SRC_PIN_CHG_TWO: begin
        vld = 1'b1;
        ofs = RIVM_OFS_PIN_CHG_TWO;  // RULE3
      end
      SRC_WATCHDOG: begin
        vld = 1'b1;
        ofs = RIVM_OFS_WATCHDOG;  // RULE3
      end

      SRC_T2_MATCH_A: begin
        vld = 1'b1;
        ofs = RIVM_OFS_T2_MATCH_A;  // RULE4
      end
      SRC_T2_MATCH_B: begin
        vld = 1'b1;
        ofs = RIVM_OFS_T2_MATCH_B;  // RULE4
      end
      SRC_T2_OVERFLOW: begin
        vld = 1'b1;
        ofs = RIVM_OFS_T2_OVERFLOW;  // RULE4
      end

      SRC_T1_CAPTURE: begin
        vld = 1'b1;
        ofs = RIVM_OFS_T1_CAPTURE;  // RULE5
      end
      SRC_T1_MATCH_A: begin
        vld = 1'b1;
        ofs = RIVM_OFS_T1_MATCH_A;  // RULE5
      end
      SRC_T1_MATCH_B: begin
        vld = 1'b1;
        ofs = RIVM_OFS_T1_MATCH_B;  // RULE5
      end
      SRC_T1_OVERFLOW: begin
        vld = 1'b1;
        ofs = RIVM_OFS_T1_OVERFLOW;  // RULE5
      end

      SRC_T0_MATCH_A: begin
        vld = 1'b1;
        ofs = RIVM_OFS_T0_MATCH_A;  // RULE6
      end
      SRC_T0_MATCH_B: begin
        vld = 1'b1;
        ofs = RIVM_OFS_T0_MATCH_B;  // RULE6
      end
      SRC_T0_OVERFLOW: begin
        vld = 1'b1;
        ofs = RIVM_OFS_T0_OVERFLOW;  // RULE6
      end

      SRC_SPI_DONE: begin
        vld = 1'b1;
        ofs = RIVM_OFS_SPI_DONE;  // RULE7
      end
      SRC_SERIAL_RX_DONE: begin
        vld = 1'b1;
        ofs = RIVM_OFS_SERIAL_RX_DONE;  // RULE7
      end
      SRC_SERIAL_TX_EMPTY: begin
        vld = 1'b1;
        ofs = RIVM_OFS_SERIAL_TX_EMPTY;  // RULE7
      end
      SRC_SERIAL_TX_DONE: begin
        vld = 1'b1;
        ofs = RIVM_OFS_SERIAL_TX_DONE;  // RULE7
      end

      SRC_CONV_DONE: begin
        vld = 1'b1;
        ofs = RIVM_OFS_CONV_DONE;  // RULE8
      end
      SRC_NV_DATA_READY: begin
        vld = 1'b1;
        ofs = RIVM_OFS_NV_DATA_READY;  // RULE8
      end
      SRC_ANALOG_CMP: begin
        vld = 1'b1;
        ofs = RIVM_OFS_ANALOG_CMP;  // RULE8
      end
      SRC_TWO_WIRE: begin
        vld = 1'b1;
        ofs = RIVM_OFS_TWO_WIRE;  // RULE8
      end
      SRC_SELF_PROG_READY: begin
        vld = 1'b1;
        ofs = RIVM_OFS_SELF_PROG_READY;  // RULE8
      end
      default: begin
        vld = 1'b0;
      end
    endcase
    rivm_entry = {vld, ofs};
  endfunction : rivm_entry

  // One word per vector: a gap or a shuffle in the table stops elaboration
  for (genvar i = 1; i <= RIVM_NSRC; i++) begin : g_one_word  // RULE13
    if (rivm_entry(RIVM_IDW'(i)) != {1'b1, AW'(i)}) begin : g_gap
      $error("rivm_vector_map: table offset must equal the source number");
    end
  end

  // ---------------------------------------------------------------
  // Table base and reset target
  // ---------------------------------------------------------------
  // Table base per select bit; table start is base plus one word
  logic [AW-1:0] table_base;
  logic [AW-1:0] reset_target;
  logic [AW:0]   irq_entry;

  always_comb begin
    // RULE11
    table_base   = VECTOR_TABLE_SELECT_BIT ? BOOT_RESET_ADDR : RIVM_RESET_ADDR; // RULE10
    irq_entry    = rivm_entry(IRQ_SOURCE);
    reset_target = (BOOT_RESET_SELECT_FUSE == 1'b0) ? BOOT_RESET_ADDR  // RULE9
                                                    : RIVM_RESET_ADDR; // RULE1
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    r_d      = r_q;
    r_d.load = 1'b0;
    case (r_q.st)
      RIVM_ST_RESET: begin
        // First cycle out of reset: redirect fetch to the reset target
        r_d.addr     = reset_target;  // RULE1
        r_d.load     = 1'b1;
        r_d.is_reset = 1'b1;
        r_d.st       = RIVM_ST_RUN;
      end
      RIVM_ST_RUN, RIVM_ST_VEC: begin
        r_d.st = RIVM_ST_RUN;
        // Only an accepted request touches a vector word; without one the
        // table words are plain code to the fetch unit
        if (IRQ_TAKEN) begin  // RULE12
          if (irq_entry[AW]) begin
            // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8
            r_d.addr     = AW'(table_base + irq_entry[AW-1:0]);  // RULE13
            r_d.load     = 1'b1;
            r_d.is_reset = 1'b0;
            r_d.st       = RIVM_ST_VEC;
          end else begin
            // Out-of-table numbers are dropped, sticky flag until reset
            r_d.err = 1'b1;
          end
        end
      end
      default: begin
        r_d.st = RIVM_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      r_q <= '{st: RIVM_ST_RESET, load: 1'b0, is_reset: 1'b0, err: 1'b0,
               addr: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------
  // Redirect outputs
  // ---------------------------------------------------------------
  assign FETCH_LOAD     = r_q.load;
  assign FETCH_ADDR     = r_q.addr;
  assign FETCH_IS_RESET = r_q.is_reset;
  assign SOURCE_ERROR   = r_q.err;

endmodule : rivm_vector_map

// >>> rivm_chk.sv
/* Checker of the redirect outputs of rivm_vector_map.
   Bound into the map; one clock, RSTN async active low. */
`timescale 1ns/1ps
module rivm_chk
  import rivm_pkg::*;
#(parameter logic [11:0] BOOT_RESET_ADDR = RIVM_BOOT_DEFAULT) (
  input wire logic        CLK,                     // Clock
  input wire logic        RSTN,                    // Reset
  input wire logic        BOOT_RESET_SELECT_FUSE,  // Fuse
  input wire logic        VECTOR_TABLE_SELECT_BIT, // Select
  input wire logic        IRQ_TAKEN,               // Strobe
  input wire logic [4:0]  IRQ_SOURCE,              // Source
  input wire logic        FETCH_LOAD,              // Load
  input wire logic [11:0] FETCH_ADDR,              // Address
  input wire logic        FETCH_IS_RESET,          // Kind
  input wire logic        SOURCE_ERROR             // Error
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire logic ok = IRQ_SOURCE != 5'h00 && IRQ_SOURCE <= 5'h19;
  chk_reset_target: assert property (
    !$past(RSTN) |=> FETCH_LOAD && FETCH_IS_RESET && FETCH_ADDR ==
    ($past(BOOT_RESET_SELECT_FUSE) ? 12'h000 : BOOT_RESET_ADDR)) else $error("Reset target");
  chk_vector_addr: assert property (
    IRQ_TAKEN && ok && $past(RSTN) |=> FETCH_LOAD && !FETCH_IS_RESET && FETCH_ADDR ==
    ($past(VECTOR_TABLE_SELECT_BIT) ? BOOT_RESET_ADDR : 12'h000) + 12'($past(IRQ_SOURCE)))
    else $error("Vector address");
  chk_bad_source: assert property (
    IRQ_TAKEN && !ok && $past(RSTN) |=> !FETCH_LOAD && SOURCE_ERROR) else $error("Bad source");
  chk_quiet_idle: assert property (
    !IRQ_TAKEN && $past(RSTN) |=> !FETCH_LOAD) else $error("Spurious load");
  chk_load_cause: assert property (
    FETCH_LOAD |-> $past(IRQ_TAKEN) || !$past(RSTN, 2)) else $error("Uncaused load");
  chk_addr_hold: assert property (
    !FETCH_LOAD |-> $stable(FETCH_ADDR) && $stable(FETCH_IS_RESET)) else $error("Address moved");
  chk_err_sticky: assert property (
    SOURCE_ERROR |=> SOURCE_ERROR) else $error("Error dropped");
  chk_err_cause: assert property (
    $rose(SOURCE_ERROR) |-> $past(IRQ_TAKEN) && !$past(ok)) else $error("Uncaused error");
  cover property (FETCH_LOAD && FETCH_IS_RESET && FETCH_ADDR == BOOT_RESET_ADDR);
  cover property (FETCH_LOAD && FETCH_ADDR == BOOT_RESET_ADDR + 12'h019);
  cover property ($rose(SOURCE_ERROR));
endmodule : rivm_chk

bind rivm_vector_map rivm_chk #(.BOOT_RESET_ADDR(BOOT_RESET_ADDR)) u_chk (.CLK(CLK),
  .RSTN(RSTN), .BOOT_RESET_SELECT_FUSE(BOOT_RESET_SELECT_FUSE), .IRQ_TAKEN(IRQ_TAKEN),
  .VECTOR_TABLE_SELECT_BIT(VECTOR_TABLE_SELECT_BIT), .IRQ_SOURCE(IRQ_SOURCE),
  .FETCH_LOAD(FETCH_LOAD), .FETCH_ADDR(FETCH_ADDR), .FETCH_IS_RESET(FETCH_IS_RESET),
  .SOURCE_ERROR(SOURCE_ERROR));

// >>> rivm_core_model.sv
/* Core-side model: one accept strobe per bench request, a cycle late.
   Assumes the bench keeps req low across reset release. */
`timescale 1ns/1ps
module rivm_core_model (
  input  wire logic       clk,     // Core clock
  input  wire logic       rst_n,   // Async reset, active low
  input  wire logic       req,     // Request a strobe
  input  wire logic [4:0] req_src, // Source to offer
  output logic            taken,   // Accept strobe
  output logic [4:0]      source   // Source, scrambled when idle
);
  // Idle source keeps toggling so a stale number is never read as valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taken <= 1'b0;
      source <= 5'h00;
    end else begin
      taken <= req;
      source <= req ? req_src : ~source;
    end
  end
endmodule : rivm_core_model

// >>> test_reset_interrupt_vector_map.sv
/* Bench for rivm_vector_map with a core-side strobe model.
   An integer model predicts every output; BOOT stays below 0xfe0. */
`timescale 1ns/1ps
module test_reset_interrupt_vector_map;
  import rivm_pkg::*;
  localparam logic [11:0] BOOT = 12'h1c0;
  logic        clk = 0, rst_n = 0, fuse = 1, sel = 0, req = 0, first = 1;
  logic        taken, load, isr, err, e_load, e_isr, e_err;
  logic [4:0]  rsrc = 5'h00, src;
  logic [11:0] addr, e_addr;
  int          miscompares = 0, num_checks = 0;
  initial forever #25 clk = ~clk;
  rivm_core_model core (.clk(clk), .rst_n(rst_n), .req(req), .req_src(rsrc), .taken(taken),
    .source(src));
  rivm_vector_map #(.BOOT_RESET_ADDR(BOOT)) dut (.CLK(clk), .RSTN(rst_n),
    .BOOT_RESET_SELECT_FUSE(fuse), .VECTOR_TABLE_SELECT_BIT(sel), .IRQ_TAKEN(taken),
    .IRQ_SOURCE(src), .FETCH_LOAD(load), .FETCH_ADDR(addr), .FETCH_IS_RESET(isr),
    .SOURCE_ERROR(err));
  task check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task results;
    $display("Checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  always @(posedge clk) begin
    e_load = rst_n & (first | taken & src != 5'h00 & src <= 5'h19);
    if (!rst_n) {e_isr, e_err, e_addr} = '0;
    else if (first) {e_isr, e_addr} = {1'b1, (fuse ? 12'h000 : BOOT)};
    else if (e_load) {e_isr, e_addr} = {1'b0, (sel ? BOOT : 12'h000) + 12'(src)};
    else e_err = e_err | taken;
    first = !rst_n;
  end
  always @(negedge clk) begin
    if (rst_n) begin
      check(12'(load), 12'(e_load));
      check(addr, e_addr);
      check(12'(isr), 12'(e_isr));
      check(12'(err), 12'(e_err));
    end
  end
  // Full code sweep back to back, bad codes included, then random traffic
  task automatic run(input logic f, input logic s);
    rst_n <= 0;
    req <= 0;
    fuse <= f;
    sel <= s;
    repeat (8) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 72; i++) begin
      @(posedge clk);
      req <= i < 32 || 1'($urandom);
      rsrc <= i < 32 ? 5'(i) : 5'($urandom);
    end
    repeat (2) @(posedge clk);
    $display("Test done: fuse %0d select %0d", f, s);
  endtask : run
  initial begin
    void'($urandom(74));
    for (int k = 0; k < 4; k++) run(1'(k >> 1), 1'(k));
    results();
  end
  initial begin
    repeat (1000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule : test_reset_interrupt_vector_map
